// ---- tag_cmd_consts.svh ----
`ifndef TAG_CMD_CONSTS_SVH
`define TAG_CMD_CONSTS_SVH

// Command codes
`define CMD_LOCK        8'h22
`define CMD_XLOCK       8'h32
`define CMD_RDMULTI     8'h23
`define CMD_XRDMULTI    8'h33

// Error codes
`define ERR_OPTION      8'h03
`define ERR_UNSPEC      8'h0f
`define ERR_NO_BLOCK    8'h10
`define ERR_LOCKED      8'h11
`define ERR_LOCK_FAIL   8'h14
`define ERR_RD_PROT     8'h15

// Response flag bytes
`define RESP_FLAG_OK    8'h00
`define RESP_FLAG_ERR   8'h01

// Request flag bit positions
`define FLAG_INV_BIT    2
`define FLAG_PEXT_BIT   3
`define FLAG_ADDR_BIT   5
`define FLAG_OPT_BIT    6

// Start positions and lengths of the parameter field, byte count cap
`define HDR_PLAIN       5'h02
`define HDR_ADDRESSED   5'h0a
`define NEED_LOCK       5'h01
`define NEED_XLOCK      5'h02
`define NEED_RD         5'h02
`define NEED_XRD        5'h04
`define BYTE_CNT_MAX    5'h1f

// Memory and block limits
`define BLOCK_COUNT     2048
`define LAST_BLOCK      17'h007ff
`define LOCKABLE_MAX    16'h0001
`define XRD_COUNT_MAX   16'h07fe
`define LAST_BYTE_SEL   2'h3

// Timing, in ns, at a 40 ns clock
`define CLK_PERIOD_NS   40
`define NOMINAL_RESPONSE_DELAY_NS        320000
`define WT_STEP_NS      302000

`endif

// ---- tag_cmd_pkg.sv ----
package tag_cmd_pkg;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_WAIT  = 4'h1,
    S_EOF   = 4'h2,
    S_FLAGS = 4'h3,
    S_ERR   = 4'h4,
    S_RADDR = 4'h5,
    S_RWAIT = 4'h6,
    S_STAT  = 4'h7,
    S_DATA  = 4'h8
  } state_type;

endpackage

// ---- block_store.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tag_cmd_consts.svh"

// Word store of user blocks; read data is registered
module block_store
(
  input  wire logic        clock_in,
  input  wire logic        wr_en_in,
  input  wire logic [10:0] wr_addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        rd_en_in,
  input  wire logic [10:0] rd_addr_in,
  output logic      [31:0] rd_data_out
);

  logic [31:0] mem_array [0:`BLOCK_COUNT-1];

  // Write port
  always_ff @(posedge clock_in)
  begin
    if (wr_en_in)
    begin
      mem_array[wr_addr_in] <= wr_data_in;
    end
  end

  // Read port, data held until the next read
  always_ff @(posedge clock_in)
  begin
    if (rd_en_in)
    begin
      rd_data_out <= mem_array[rd_addr_in];
    end
  end

endmodule
`default_nettype wire

// ---- tag_cmd_engine.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tag_cmd_consts.svh"

module tag_cmd_engine
#(
  parameter int unsigned LOCK_WAIT_CYCLES = (`NOMINAL_RESPONSE_DELAY_NS + `WT_STEP_NS) / `CLK_PERIOD_NS
)
(
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic        req_sof_in,
  input  wire logic        req_byte_valid_in,
  input  wire logic [7:0]  req_byte_in,
  input  wire logic        req_eof_in,
  input  wire logic        resp_ready_in,
  output logic             resp_valid_out,
  output logic      [7:0]  resp_data_out,
  output logic             resp_last_out,
  input  wire logic [10:0] area1_end_in,
  input  wire logic [10:0] area2_end_in,
  input  wire logic [10:0] area3_end_in,
  input  wire logic [3:0]  rf_area_security_bits_in,
  input  wire logic [1:0]  nv_lock_init_in,
  input  wire logic        lock_prog_fail_in,
  input  wire logic        host_wr_in,
  input  wire logic [10:0] host_wr_addr_in,
  input  wire logic [31:0] host_wr_data_in,
  output logic             host_wr_refused_out,
  output logic      [1:0]  lock_state_out
);

  tag_cmd_pkg::state_type state_reg;
  logic        rst_meta_reg;
  logic        rst_b_reg;
  logic        rst_b;
  logic [4:0]  byte_cnt_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  param_reg [0:3];
  logic [4:0]  hdr_len;
  logic [4:0]  param_idx;
  logic        is_lock;
  logic        is_rd;
  logic        is_ext;
  logic [4:0]  need_len;
  logic        frame_ok;
  logic [15:0] first_blk;
  logic [15:0] count_fld;
  logic [16:0] last_blk;
  logic [7:0]  dec_code;
  logic        dec_err;
  logic        err_reg;
  logic [7:0]  err_code_reg;
  logic        opt_reg;
  logic        lock_op_reg;
  logic [10:0] cur_reg;
  logic [15:0] remain_reg;
  logic [1:0]  byte_sel_reg;
  logic [15:0] wait_cnt_reg;
  logic [1:0]  lock_reg;
  logic        loaded_reg;
  logic        set_lock;
  logic        cur_locked;
  logic        emit_en;
  logic        emit_go;
  logic [7:0]  emit_byte;
  logic        emit_last;
  logic        host_locked;
  logic        rd_en;
  logic [31:0] rd_word;
  logic        resp_valid_reg;
  logic [7:0]  resp_data_reg;
  logic        resp_last_reg;
  logic        refused_reg;

  // Area index of a block from the three area end marks
  function automatic logic [1:0] area_of(input logic [10:0] blk);
    if (blk <= area1_end_in)
      area_of = 2'h0;
    else if (blk <= area2_end_in)
      area_of = 2'h1;
    else if (blk <= area3_end_in)
      area_of = 2'h2;
    else
      area_of = 2'h3;
  endfunction

  // Reset: asserted at once, released through two flops
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_b_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_b_reg    <= rst_meta_reg;
    end
  end
  assign rst_b = rst_b_reg;

  // Request byte capture; UID bytes are skipped, not checked here
  assign hdr_len   = flags_reg[`FLAG_ADDR_BIT] ? `HDR_ADDRESSED : `HDR_PLAIN;
  assign param_idx = byte_cnt_reg - hdr_len;
  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      byte_cnt_reg <= 5'h00;
      flags_reg    <= 8'h00;
      cmd_reg      <= 8'h00;
      for (int i = 0; i < 4; i++)
        param_reg[i] <= 8'h00;
    end
    else if (req_sof_in)
      byte_cnt_reg <= 5'h00;
    else if (req_byte_valid_in && state_reg == tag_cmd_pkg::S_IDLE)
    begin
      if (byte_cnt_reg == 5'h00)
        flags_reg <= req_byte_in;
      else if (byte_cnt_reg == 5'h01)
        cmd_reg <= req_byte_in;
      else if (byte_cnt_reg >= hdr_len && param_idx < 5'h04)
        param_reg[param_idx[1:0]] <= req_byte_in;
      if (byte_cnt_reg != `BYTE_CNT_MAX)
        byte_cnt_reg <= byte_cnt_reg + 5'h01;
    end
  end

  // Field decode, LSB byte first on extended forms
  assign is_lock   = cmd_reg == `CMD_LOCK || cmd_reg == `CMD_XLOCK;
  assign is_rd     = cmd_reg == `CMD_RDMULTI || cmd_reg == `CMD_XRDMULTI;
  assign is_ext    = cmd_reg == `CMD_XLOCK || cmd_reg == `CMD_XRDMULTI;
  assign need_len  = is_lock ? (is_ext ? `NEED_XLOCK : `NEED_LOCK)
                             : (is_ext ? `NEED_XRD : `NEED_RD);
  assign frame_ok  = (is_lock || is_rd) && byte_cnt_reg >= hdr_len + need_len
                     && !flags_reg[`FLAG_INV_BIT];
  assign first_blk = is_ext ? {param_reg[1], param_reg[0]} : {8'h00, param_reg[0]};
  assign count_fld = is_ext ? {param_reg[3], param_reg[2]} : {8'h00, param_reg[1]};
  assign last_blk  = {1'b0, first_blk} + {1'b0, count_fld};

  // Error decision; the first failing check names the code
  always_comb
  begin
    dec_err  = 1'b1;
    dec_code = `ERR_OPTION;
    if (flags_reg[`FLAG_PEXT_BIT])
      dec_code = `ERR_OPTION;
    else if (is_lock && first_blk > `LOCKABLE_MAX)
      dec_code = `ERR_NO_BLOCK;
    else if (is_lock && lock_reg[first_blk[0]])
      dec_code = `ERR_LOCKED;
    else if (is_lock)
      dec_err = 1'b0;
    else if (is_ext && count_fld > `XRD_COUNT_MAX)
      dec_code = `ERR_UNSPEC;
    else if (last_blk > `LAST_BLOCK)
      dec_code = `ERR_NO_BLOCK;
    else if (area_of(first_blk[10:0]) != area_of(last_blk[10:0]))
      dec_code = `ERR_NO_BLOCK;
    else if (rf_area_security_bits_in[area_of(first_blk[10:0])])
      dec_code = `ERR_RD_PROT;
    else
      dec_err = 1'b0;
  end

  // Response byte selection
  assign cur_locked = cur_reg <= 11'h001 && lock_reg[cur_reg[0]];
  always_comb
  begin
    emit_en   = 1'b1;
    emit_byte = 8'h00;
    emit_last = 1'b0;
    unique case (state_reg)
      tag_cmd_pkg::S_FLAGS:
      begin
        emit_byte = err_reg ? `RESP_FLAG_ERR : `RESP_FLAG_OK;
        emit_last = !err_reg && lock_op_reg;
      end
      tag_cmd_pkg::S_ERR:
      begin
        emit_byte = err_code_reg;
        emit_last = 1'b1;
      end
      tag_cmd_pkg::S_STAT:
        emit_byte = {7'h00, cur_locked};
      tag_cmd_pkg::S_DATA:
      begin
        emit_byte = rd_word[{byte_sel_reg, 3'h0} +: 8];
        emit_last = byte_sel_reg == `LAST_BYTE_SEL && remain_reg == 16'h0000;
      end
      tag_cmd_pkg::S_IDLE, tag_cmd_pkg::S_WAIT, tag_cmd_pkg::S_EOF,
      tag_cmd_pkg::S_RADDR, tag_cmd_pkg::S_RWAIT:
        emit_en = 1'b0;
    endcase
  end
  // A byte leaves only when the output slot is free or being taken
  assign emit_go = emit_en && (!resp_valid_reg || resp_ready_in);

  // Command sequencer
  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg    <= tag_cmd_pkg::S_IDLE;
      err_reg      <= 1'b0;
      err_code_reg <= 8'h00;
      opt_reg      <= 1'b0;
      lock_op_reg  <= 1'b0;
      cur_reg      <= 11'h000;
      remain_reg   <= 16'h0000;
      byte_sel_reg <= 2'h0;
      wait_cnt_reg <= 16'h0000;
    end
    else
    begin
      unique case (state_reg)
        tag_cmd_pkg::S_IDLE:
          if (req_eof_in && frame_ok)
          begin
            err_reg      <= dec_err;
            err_code_reg <= dec_code;
            opt_reg      <= flags_reg[`FLAG_OPT_BIT];
            lock_op_reg  <= is_lock;
            cur_reg      <= first_blk[10:0];
            remain_reg   <= count_fld;
            wait_cnt_reg <= 16'(LOCK_WAIT_CYCLES);
            if (is_lock && !dec_err)
              state_reg <= tag_cmd_pkg::S_WAIT;
            else
              state_reg <= tag_cmd_pkg::S_FLAGS;
          end
        tag_cmd_pkg::S_WAIT:
          if (wait_cnt_reg != 16'h0000)
            wait_cnt_reg <= wait_cnt_reg - 16'h0001;
          else
          begin
            if (lock_prog_fail_in)
            begin
              err_reg      <= 1'b1;
              err_code_reg <= `ERR_LOCK_FAIL;
            end
            state_reg <= opt_reg ? tag_cmd_pkg::S_EOF : tag_cmd_pkg::S_FLAGS;
          end
        tag_cmd_pkg::S_EOF:
          if (req_eof_in)
            state_reg <= tag_cmd_pkg::S_FLAGS;
        tag_cmd_pkg::S_FLAGS:
          if (emit_go)
          begin
            if (err_reg)
              state_reg <= tag_cmd_pkg::S_ERR;
            else if (lock_op_reg)
              state_reg <= tag_cmd_pkg::S_IDLE;
            else
              state_reg <= tag_cmd_pkg::S_RADDR;
          end
        tag_cmd_pkg::S_ERR:
          if (emit_go)
            state_reg <= tag_cmd_pkg::S_IDLE;
        tag_cmd_pkg::S_RADDR:
          state_reg <= tag_cmd_pkg::S_RWAIT;
        tag_cmd_pkg::S_RWAIT:
        begin
          byte_sel_reg <= 2'h0;
          state_reg    <= opt_reg ? tag_cmd_pkg::S_STAT : tag_cmd_pkg::S_DATA;
        end
        tag_cmd_pkg::S_STAT:
          if (emit_go)
            state_reg <= tag_cmd_pkg::S_DATA;
        tag_cmd_pkg::S_DATA:
          if (emit_go)
          begin
            byte_sel_reg <= byte_sel_reg + 2'h1;
            if (byte_sel_reg == `LAST_BYTE_SEL)
            begin
              if (remain_reg == 16'h0000)
                state_reg <= tag_cmd_pkg::S_IDLE;
              else
              begin
                cur_reg    <= cur_reg + 11'h001;
                remain_reg <= remain_reg - 16'h0001;
                state_reg  <= tag_cmd_pkg::S_RADDR;
              end
            end
          end
      endcase
    end
  end

  // Lock bits: caught from storage after reset, only ever set
  assign set_lock = state_reg == tag_cmd_pkg::S_WAIT && wait_cnt_reg == 16'h0000
                    && !lock_prog_fail_in;
  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lock_reg   <= 2'h0;
      loaded_reg <= 1'b0;
    end
    else if (!loaded_reg)
    begin
      lock_reg   <= nv_lock_init_in;
      loaded_reg <= 1'b1;
    end
    else if (set_lock)
      lock_reg[cur_reg[0]] <= 1'b1;
  end

  // Host writes; a locked block is never touched once the lock bits are loaded
  assign host_locked = host_wr_addr_in <= 11'h001 && lock_reg[host_wr_addr_in[0]];
  assign rd_en       = state_reg == tag_cmd_pkg::S_RADDR;
  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
      refused_reg <= 1'b0;
    else
      refused_reg <= host_wr_in && host_locked;
  end

  block_store u_store
  (
    .clock_in   (clock_in),
    .wr_en_in   (host_wr_in && !host_locked),
    .wr_addr_in (host_wr_addr_in),
    .wr_data_in (host_wr_data_in),
    .rd_en_in   (rd_en),
    .rd_addr_in (cur_reg),
    .rd_data_out(rd_word)
  );

  // Output byte slot, held until taken
  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resp_valid_reg <= 1'b0;
      resp_data_reg  <= 8'h00;
      resp_last_reg  <= 1'b0;
    end
    else if (emit_go)
    begin
      resp_valid_reg <= 1'b1;
      resp_data_reg  <= emit_byte;
      resp_last_reg  <= emit_last;
    end
    else if (resp_ready_in)
      resp_valid_reg <= 1'b0;
  end

  assign resp_valid_out      = resp_valid_reg;
  assign resp_data_out       = resp_data_reg;
  assign resp_last_out       = resp_last_reg;
  assign host_wr_refused_out = refused_reg;
  assign lock_state_out      = lock_reg;

  // Checks
  property p_lock_sticky;
    @(posedge clock_in) disable iff (!rst_b)
    loaded_reg && $past(loaded_reg) |-> (lock_reg & $past(lock_reg)) == $past(lock_reg);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");

  property p_refuse;
    @(posedge clock_in) disable iff (!rst_b)
    host_wr_in && host_wr_addr_in == 11'h000 && lock_reg[0] |=> host_wr_refused_out;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write to locked block taken");

  property p_lock_range;
    @(posedge clock_in) disable iff (!rst_b)
    state_reg == tag_cmd_pkg::S_WAIT |-> cur_reg <= 11'h001;
  endproperty
  a_lock_range: assert property (p_lock_range) else $error("lock of high block");

  property p_eof_hold;
    @(posedge clock_in) disable iff (!rst_b)
    state_reg == tag_cmd_pkg::S_EOF && !req_eof_in |=> !resp_valid_out[*2];
  endproperty
  a_eof_hold: assert property (p_eof_hold) else $error("answer before EOF");

  property p_fail_keeps;
    @(posedge clock_in) disable iff (!rst_b)
    state_reg == tag_cmd_pkg::S_WAIT && wait_cnt_reg == 16'h0000 && lock_prog_fail_in
      |=> $stable(lock_reg) ##0 err_code_reg == `ERR_LOCK_FAIL;
  endproperty
  a_fail_keeps: assert property (p_fail_keeps) else $error("failed lock changed state");

  property p_status_byte;
    @(posedge clock_in) disable iff (!rst_b)
    state_reg == tag_cmd_pkg::S_STAT && emit_go |=> resp_data_out[7:1] == 7'h00;
  endproperty
  a_status_byte: assert property (p_status_byte) else $error("status high bits set");

  property p_ascend;
    @(posedge clock_in) disable iff (!rst_b)
    state_reg == tag_cmd_pkg::S_DATA && emit_go && byte_sel_reg == `LAST_BYTE_SEL
      && remain_reg != 16'h0000 |=> cur_reg == $past(cur_reg) + 11'h001;
  endproperty
  a_ascend: assert property (p_ascend) else $error("blocks out of order");

  property p_range;
    @(posedge clock_in) disable iff (!rst_b)
    state_reg == tag_cmd_pkg::S_RADDR |-> {6'h00, cur_reg} + {1'b0, remain_reg} <= `LAST_BLOCK;
  endproperty
  a_range: assert property (p_range) else $error("read past user memory");

  property p_inv_ignored;
    @(posedge clock_in) disable iff (!rst_b)
    state_reg == tag_cmd_pkg::S_IDLE && req_eof_in && flags_reg[`FLAG_INV_BIT]
      |=> state_reg == tag_cmd_pkg::S_IDLE;
  endproperty
  a_inv_ignored: assert property (p_inv_ignored) else $error("inventory request served");

  c_lock_done: cover property (@(posedge clock_in) disable iff (!rst_b) set_lock);
  c_read_last: cover property (@(posedge clock_in) disable iff (!rst_b)
    resp_valid_out && resp_last_out && !lock_op_reg && !err_reg);
  c_err_sent: cover property (@(posedge clock_in) disable iff (!rst_b)
    state_reg == tag_cmd_pkg::S_ERR && emit_go);

endmodule
`default_nettype wire

// ---- reader_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Reader on the far side of the request link; drives on the falling edge
module reader_model
(
  input  wire logic       clock_in,
  input  wire logic       stall_in,
  output logic            req_sof_out,
  output logic            req_byte_valid_out,
  output logic      [7:0] req_byte_out,
  output logic            req_eof_out,
  output logic            resp_ready_out
);
  initial
  begin
    req_sof_out = 1'b0;
    req_byte_valid_out = 1'b0;
    req_byte_out = 8'h00;
    req_eof_out = 1'b0;
  end

  // Random back-pressure, so every response byte must stand until taken
  always @(negedge clock_in)
    resp_ready_out <= stall_in ? 1'($urandom()) : 1'b1;

  // Frame: start pulse, one pulse per byte, then end pulse unless held back
  task automatic send_frame(input logic [7:0] fr[$], input logic hold_eof);
    @(negedge clock_in);
    req_sof_out <= 1'b1;
    @(negedge clock_in);
    req_sof_out <= 1'b0;
    foreach (fr[i])
    begin
      req_byte_valid_out <= 1'b1;
      req_byte_out <= fr[i];
      @(negedge clock_in);
      req_byte_valid_out <= 1'b0;
      req_byte_out <= ~fr[i]; // Stale byte never looks valid
      @(negedge clock_in);
    end
    if (!hold_eof)
      send_eof();
  endtask

  // Silent until here, so no modulation lands in a write cycle
  task automatic send_eof();
    req_eof_out <= 1'b1;
    @(negedge clock_in);
    req_eof_out <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- tb_tag_cmd_engine.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_tag_cmd_engine;
  localparam int unsigned WAIT_CYC = 20;
  localparam logic [7:0]  FL = 8'h02; // Inventory bit cleared

  logic        clock_in;
  logic        rst_b_in;
  logic        stall;
  logic        req_sof;
  logic        req_byte_valid;
  logic [7:0]  req_byte;
  logic        req_eof;
  logic        resp_ready;
  logic        resp_valid_out;
  logic [7:0]  resp_data_out;
  logic        resp_last_out;
  logic [10:0] area_end [0:2];
  logic [3:0]  sec_bits;
  logic [1:0]  nv_lock;
  logic        prog_fail;
  logic        host_wr;
  logic [10:0] host_addr;
  logic [31:0] host_data;
  logic        refused_out;
  logic [1:0]  lock_state_out;
  logic [31:0] mem [0:15];
  logic [1:0]  lock_exp;
  logic [8:0]  exp_q [$];
  int          err_count;
  int          checks_done;

  tag_cmd_engine #(.LOCK_WAIT_CYCLES(WAIT_CYC)) u_tag_cmd_engine
  (
    .clock_in                (clock_in),
    .rst_b_in                (rst_b_in),
    .req_sof_in              (req_sof),
    .req_byte_valid_in       (req_byte_valid),
    .req_byte_in             (req_byte),
    .req_eof_in              (req_eof),
    .resp_ready_in           (resp_ready),
    .resp_valid_out          (resp_valid_out),
    .resp_data_out           (resp_data_out),
    .resp_last_out           (resp_last_out),
    .area1_end_in            (area_end[0]),
    .area2_end_in            (area_end[1]),
    .area3_end_in            (area_end[2]),
    .rf_area_security_bits_in(sec_bits),
    .nv_lock_init_in         (nv_lock),
    .lock_prog_fail_in       (prog_fail),
    .host_wr_in              (host_wr),
    .host_wr_addr_in         (host_addr),
    .host_wr_data_in         (host_data),
    .host_wr_refused_out     (refused_out),
    .lock_state_out          (lock_state_out)
  );

  reader_model u_reader_model
  (
    .clock_in          (clock_in),
    .stall_in          (stall),
    .req_sof_out       (req_sof),
    .req_byte_valid_out(req_byte_valid),
    .req_byte_out      (req_byte),
    .req_eof_out       (req_eof),
    .resp_ready_out    (resp_ready)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_byte(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t response byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // Watcher: each byte taken is matched against the oldest note
  always @(posedge clock_in)
    if (rst_b_in === 1'b1 && resp_valid_out === 1'b1 && resp_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        err_count++;
        $display("BAD %0t unexpected response byte", $time);
      end
      else
        chk_byte({resp_last_out, resp_data_out}, exp_q.pop_front());
    end

  task automatic wait_done();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 600)
    begin
      @(negedge clock_in);
      n++;
    end
    if (exp_q.size() != 0)
    begin
      err_count++;
      $display("BAD %0t response timeout", $time);
      conclude();
    end
    else
      repeat (3) @(negedge clock_in);
  endtask

  // Error answer: flags byte with error bit, then the code
  task automatic err_case(input logic [7:0] fr[$], input logic [7:0] code);
    exp_q.push_back({1'b0, 8'h01});
    exp_q.push_back({1'b1, code});
    u_reader_model.send_frame(fr, 1'b0);
    wait_done();
  endtask

  // Good read: flags byte, then per block an optional status byte and the word, low byte first
  task automatic rd_case(input logic [7:0] fr[$], input int first, input int cnt,
                         input logic opt);
    exp_q.push_back({1'b0, 8'h00});
    for (int b = first; b < first + cnt; b++)
    begin
      if (opt)
        exp_q.push_back({1'b0, 7'h00, (b < 2) ? lock_exp[b] : 1'b0});
      for (int i = 0; i < 4; i++)
        exp_q.push_back({1'((b == first + cnt - 1) && (i == 3)), mem[b][8*i +: 8]});
    end
    u_reader_model.send_frame(fr, 1'b0);
    wait_done();
  endtask

  // Plain lock with no option: a lone good flags byte after the wait
  task automatic lock_ok(input logic [7:0] fr[$]);
    exp_q.push_back({1'b1, 8'h00});
    u_reader_model.send_frame(fr, 1'b0);
    wait_done();
  endtask

  // Refusal may land one or two edges after the write edge
  task automatic host_write(input logic [10:0] a, input logic [31:0] d, input logic refuse);
    logic seen;
    host_wr = 1'b1;
    host_addr = a;
    host_data = d;
    @(negedge clock_in);
    host_wr = 1'b0;
    seen = refused_out;
    @(negedge clock_in);
    seen = seen | refused_out;
    chk_val({31'h0, seen}, {31'h0, refuse});
    if (!refuse)
      mem[a] = d;
  endtask

  initial
  begin
    rst_b_in = 1'b0;
    stall = 1'b0;
    area_end[0] = 11'h003;
    area_end[1] = 11'h007;
    area_end[2] = 11'h00f;
    sec_bits = 4'hc; // Whole areas 2 and 3 guarded by their bits
    nv_lock = 2'h0;
    prog_fail = 1'b0;
    host_wr = 1'b0;
    host_addr = 11'h000;
    host_data = 32'h0;
    lock_exp = 2'h0;
    err_count = 0;
    checks_done = 0;
    void'($urandom(32'hbe8bfc47));
    repeat (20) @(negedge clock_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge clock_in);
    chk_val({30'h0, lock_state_out}, {30'h0, lock_exp});
    stall = 1'b1;
    for (int b = 0; b < 10; b++)
      host_write(11'(b), $urandom(), 1'b0);
    rd_case('{FL, 8'h23, 8'h00, 8'h03}, 0, 4, 1'b0);
    lock_ok('{FL, 8'h22, 8'h01});
    lock_exp = 2'h2;
    chk_val({30'h0, lock_state_out}, {30'h0, lock_exp});
    host_write(11'h001, $urandom(), 1'b1);
    rd_case('{8'h42, 8'h23, 8'h00, 8'h01}, 0, 2, 1'b1);
    prog_fail = 1'b1;
    err_case('{FL, 8'h22, 8'h00}, 8'h14);
    prog_fail = 1'b0;
    chk_val({30'h0, lock_state_out}, {30'h0, lock_exp});
    // Option set: request ends normally, answer only after a second end pulse
    u_reader_model.send_frame('{8'h42, 8'h32, 8'h00, 8'h00}, 1'b0);
    repeat (3 * WAIT_CYC) @(negedge clock_in);
    chk_val({31'h0, resp_valid_out}, 32'h0);
    exp_q.push_back({1'b1, 8'h00});
    u_reader_model.send_eof();
    wait_done();
    lock_exp = 2'h3;
    chk_val({30'h0, lock_state_out}, {30'h0, lock_exp});
    host_write(11'h000, $urandom(), 1'b1);
    err_case('{FL, 8'h22, 8'h01}, 8'h11);
    err_case('{FL, 8'h22, 8'h02}, 8'h10);
    err_case('{FL, 8'h32, 8'h00, 8'h01}, 8'h10);
    err_case('{8'h0a, 8'h23, 8'h00, 8'h00}, 8'h03);
    err_case('{FL, 8'h23, 8'h02, 8'h03}, 8'h10);
    err_case('{FL, 8'h23, 8'h08, 8'h00}, 8'h15);
    err_case('{FL, 8'h33, 8'hff, 8'h07, 8'h01, 8'h00}, 8'h10);
    err_case('{FL, 8'h33, 8'h00, 8'h00, 8'hff, 8'h07}, 8'h0f);
    chk_val({30'h0, lock_state_out}, {30'h0, lock_exp});
    rd_case('{8'h42, 8'h33, 8'h00, 8'h00, 8'h01, 8'h00}, 0, 2, 1'b1);
    // Inventory flag set: the tag stays silent
    u_reader_model.send_frame('{8'h06, 8'h23, 8'h00, 8'h00}, 1'b0);
    repeat (40) @(negedge clock_in);
    chk_val({31'h0, resp_valid_out}, 32'h0);
    rd_case('{FL, 8'h23, 8'h00, 8'h00}, 0, 1, 1'b0);
    // Addressed form: eight identifier bytes sit before the parameters
    rd_case('{8'h22, 8'h23, 8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h5a,
              8'h02, 8'h01}, 2, 2, 1'b0);
    conclude();
  end
endmodule

`default_nettype wire
